/* File: atq_checker.sv */
// Port assertions for the trigger qualifier.
// Assumes CTRL is written with byte lane 0 enabled.
`timescale 1ns/100ps
`include "atq_params.svh"
module atq_checker (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    // Register bus
    input wire logic [7:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // Probes
    input wire logic [15:0] PROBE_DATA,
    input wire logic [15:0] PROBE_GLITCH,
    // Results
    input wire logic        TRIG_OUT,
    input wire logic        QUAL2_OUT
);
    logic [3:0] ctrl_r;
    // Shadow of the mode bits, taken from accepted writes
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            ctrl_r <= 4'h0;
        else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
                 && AVS_ADDRESS == `ATQ_OFS_CTRL)
            ctrl_r <= AVS_WRITEDATA[3:0];
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    a_wait_once: assert property ((AVS_READ || AVS_WRITE)
        && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("long wait");
    a_idle_nowait: assert property (!(AVS_READ || AVS_WRITE)
        |-> !AVS_WAITREQUEST) else $error("wait while idle");
    a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS >= `ATQ_REC_END |-> AVS_READDATA == 32'h0)
        else $error("unmapped read");
    a_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data moved");
    a_trig_pulse: assert property (TRIG_OUT |=> !TRIG_OUT)
        else $error("long trigger");
    a_trig_run: assert property (TRIG_OUT |-> $past(ctrl_r[0]))
        else $error("trigger while stopped");
    a_qual2_single: assert property (
        !ctrl_r[3] && !$past(ctrl_r[3]) |-> !QUAL2_OUT)
        else $error("qual2 active");
    a_lt_on_end: assert property (
        TRIG_OUT && ctrl_r[1] && $past(ctrl_r, 3) == ctrl_r
        |-> $past(PROBE_DATA, 1) != $past(PROBE_DATA, 2))
        else $error("lt trigger, no end");
    a_gt_edge_cause: assert property (
        TRIG_OUT && ctrl_r[2:1] == 2'h0 && $past(ctrl_r, 3) == ctrl_r
        |-> $past(PROBE_DATA, 1) != $past(PROBE_DATA, 2))
        else $error("no edge");
    a_gt_any_cause: assert property (
        TRIG_OUT && !ctrl_r[1] && $past(ctrl_r, 3) == ctrl_r
        |-> $past(PROBE_DATA, 1) != $past(PROBE_DATA, 2)
            || $past(PROBE_GLITCH, 1) != 16'h0)
        else $error("no edge or glitch");
endmodule

/* File: atq_params.svh */
// Constants for the trigger qualifier: register map, fields, timing.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef ATQ_PARAMS_SVH
`define ATQ_PARAMS_SVH

// Geometry
`define ATQ_NCH         16
`define ATQ_NREC        8
`define ATQ_LBL_W       8
`define ATQ_NLBL        2
`define ATQ_ADDR_W      8

// Register byte offsets
`define ATQ_OFS_CTRL    8'h00
`define ATQ_OFS_STAT    8'h04
`define ATQ_OFS_DUR     8'h08
`define ATQ_OFS_PVAL    8'h0C
`define ATQ_OFS_PCARE   8'h10
`define ATQ_OFS_EDGE    8'h14
`define ATQ_OFS_GLEN    8'h18
`define ATQ_OFS_RANGE   8'h1C
`define ATQ_OFS_QUAL1   8'h20
`define ATQ_OFS_QUAL2   8'h24
`define ATQ_OFS_HITS    8'h28
`define ATQ_OFS_REC     8'h40
`define ATQ_REC_END     8'h80

// Control bits
`define ATQ_CTRL_RUN    0
`define ATQ_CTRL_LT     1
`define ATQ_CTRL_GLITCH 2
`define ATQ_CTRL_DUAL   3
`define ATQ_CTRL_W      4

// Status bits
`define ATQ_ST_ARMED    0
`define ATQ_ST_TRIG     1
`define ATQ_ST_PAT      2

// Qualifier fields
`define ATQ_Q_KIND      2:0
`define ATQ_Q_IDX       5:3
`define ATQ_Q_G1MASK    9:6
`define ATQ_Q_RMODE     11:10
`define ATQ_Q_G1AND     12
`define ATQ_Q_G2MASK    16:13
`define ATQ_Q_G2AND     17
`define ATQ_Q_W         18

// Timing, clock period 50 ns
`define ATQ_CLK_NS      50
`define ATQ_GT_MIN_NS   30
`define ATQ_LT_MIN_NS   40
`define ATQ_OCC_MIN_NS  20
`define ATQ_GLITCH_NS   5
`define ATQ_MAX_MS      10
`define ATQ_NS_PER_MS   1000000
`define ATQ_DUR_RST     32'h0000001E
`define ATQ_RST_Z32     32'h00000000
`define ATQ_RST_Z16     16'h0000

`endif

/* File: atq_pkg.sv */
// Types shared by the trigger qualifier.
// Assumes atq_params.svh for all numeric constants.
package atq_pkg;

    typedef enum logic [1:0] {
        ATQ_EDGE_NONE,
        ATQ_EDGE_RISE,
        ATQ_EDGE_FALL,
        ATQ_EDGE_EITHER
    } atq_edge_t;

    typedef enum logic [2:0] {
        ATQ_Q_ANY,
        ATQ_Q_NONE,
        ATQ_Q_REC,
        ATQ_Q_NREC,
        ATQ_Q_RANGE,
        ATQ_Q_NRANGE,
        ATQ_Q_COMB
    } atq_qkind_t;

    typedef enum logic [1:0] {
        ATQ_R_OFF,
        ATQ_R_IN,
        ATQ_R_OUT
    } atq_rmode_t;

endpackage

/* File: atq_probe_model.sv */
// Probe model: the target system as seen through the input pods.
// Assumes the bench supplies the next sample; launched on the clock.
`timescale 1ns/100ps
module atq_probe_model (
    // Clock
    input  wire logic        clk,
    // Next samples from the bench
    input  wire logic [15:0] data_nxt,
    input  wire logic [15:0] glitch_nxt,
    input  wire logic [15:0] s1_nxt,
    input  wire logic [15:0] s2_nxt,
    // Pod outputs
    output logic      [15:0] data_r,
    output logic      [15:0] glitch_r,
    output logic      [15:0] s1_r,
    output logic      [15:0] s2_r
);
    always_ff @(posedge clk) begin
        data_r <= data_nxt;
        glitch_r <= glitch_nxt;
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
    end
endmodule

/* File: atq_trigger_qualifier.sv */
// Logic analyzer trigger qualification: timing trigger and state
// qualifiers, configured over an Avalon-MM slave.
// Assumes probe inputs already sampled on CORE_CLK and a glitch flag per
// channel from the acquisition front end.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "atq_params.svh"

// How it works
// RL1: Duration comparator offers greater-than and less-than senses.
// RL2: Greater-than threshold is held between 30 ns and 10 ms.
// RL3: Less-than threshold is held between 40 ns and 10 ms.
// RL4: Out-of-range duration writes clamp to the nearest limit.
// RL5: Greater-than: pattern must outlast threshold before trigger search arms.
// RL6: Less-than: edges and glitches off, trigger when qualifying pattern ends.
// RL7: Less-than occurrence needs at least 20 ns and under threshold.
// RL8: Each channel has edge setting none, rising, falling or either.
// RL9: Any one enabled edge on any channel gives a hit.
// RL10: Edge counts only after duration met, with pattern still true.
// RL11: Glitches OR edges, then AND with pattern gives trigger.
// RL12: Glitch trigger enables act only in glitch acquisition mode.
// RL13: Recognizers compare bits to 0, 1 or don't care; eight exist.
// RL14: Recognizers form groups a-d and e-h.
// RL15: Dual mode: a-d and range serve analyzer one, e-h analyzer two.
// RL16: Range recognizer matches values between both bounds inclusive.
// RL17: Qualifier is any, none, recognizer, range, complement or combination.
// RL18: Dual mode combination is one OR gate over own four recognizers.
// RL19: Pattern is the AND of every label's own match.
// RL20: Glitches narrower than 5 ns are not reported.
// RL21: Duration restarts at zero when the pattern goes false.
module atq_trigger_qualifier
    import atq_pkg::*;
#(
    parameter int DUR_MAX_CYC =
        `ATQ_MAX_MS * (`ATQ_NS_PER_MS / `ATQ_CLK_NS)
) (
    // Clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RSTN,
    // Avalon-MM slave
    input  wire logic [`ATQ_ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // Timing probes
    input  wire logic [`ATQ_NCH-1:0]    PROBE_DATA,
    input  wire logic [`ATQ_NCH-1:0]    PROBE_GLITCH,
    // State probes, one set per state analyzer
    input  wire logic [`ATQ_NCH-1:0]    STATE1_DATA,
    input  wire logic [`ATQ_NCH-1:0]    STATE2_DATA,
    // Results
    output logic                        TRIG_OUT,
    output logic                        QUAL1_OUT,
    output logic                        QUAL2_OUT
);

    localparam logic [31:0] MAX_NS =
        32'(DUR_MAX_CYC * `ATQ_CLK_NS);
    localparam logic [31:0] CLK_NS = 32'(`ATQ_CLK_NS);
    localparam logic [31:0] OCC_MIN = 32'(`ATQ_OCC_MIN_NS);

    // Register file
    logic [`ATQ_CTRL_W-1:0] ctrl_r;
    logic [31:0]            dur_r;
    logic [`ATQ_NCH-1:0]    pval_r;
    logic [`ATQ_NCH-1:0]    pcare_r;
    logic [31:0]            edge_r;
    logic [`ATQ_NCH-1:0]    glen_r;
    logic [31:0]            range_r;
    logic [`ATQ_Q_W-1:0]    qual1_r;
    logic [`ATQ_Q_W-1:0]    qual2_r;
    logic [`ATQ_NCH-1:0]    rec_val_r  [`ATQ_NREC];
    logic [`ATQ_NCH-1:0]    rec_care_r [`ATQ_NREC];

    // Bus handshake
    logic        req;
    logic        resp_r;
    logic        wr_go;
    logic [31:0] rd_nxt;
    logic [31:0] wmask;
    logic [31:0] wdat;

    // Timing trigger state
    logic [31:0]         cnt_ns_r;
    logic [31:0]         cnt_nxt;
    logic                pat_prev_r;
    logic [`ATQ_NCH-1:0] data_prev_r;
    logic                armed_r;
    logic                trig_done_r;
    logic                pat_hit;
    logic                edge_any;
    logic                glitch_any;
    logic                fire;
    logic                rearm;
    logic [`ATQ_NCH-1:0] edge_hit;
    logic [`ATQ_NLBL-1:0] lbl_hit;

    // State recognizers
    logic [`ATQ_NREC-1:0] rec1;
    logic [`ATQ_NREC-1:0] rec2;
    logic                 rng1;
    logic                 rng2;
    logic                 sense_lt;
    logic                 glitch_mode;
    logic                 dual;

    assign sense_lt    = ctrl_r[`ATQ_CTRL_LT];
    assign glitch_mode = ctrl_r[`ATQ_CTRL_GLITCH];
    assign dual        = ctrl_r[`ATQ_CTRL_DUAL];

    function automatic logic [31:0] clamp_dur(
        input logic [31:0] v,
        input logic        lt
    );
        logic [31:0] lo;
        lo = lt ? 32'(`ATQ_LT_MIN_NS) : 32'(`ATQ_GT_MIN_NS); // [RL2] [RL3]
        clamp_dur = (v < lo) ? lo : (v > MAX_NS) ? MAX_NS : v; // [RL4]
    endfunction

    // Bus: one wait cycle, then the answer
    assign req             = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = req && !resp_r;
    assign wr_go           = AVS_WRITE && resp_r;
    assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    // Lane merge over the addressed register's current value
    assign wdat = (rd_nxt & ~wmask) | (AVS_WRITEDATA & wmask);

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            resp_r <= 1'b0;
        end else begin
            resp_r <= req && !resp_r;
        end
    end

    always_comb begin
        rd_nxt = `ATQ_RST_Z32;
        if (AVS_ADDRESS == `ATQ_OFS_CTRL) begin
            rd_nxt[`ATQ_CTRL_W-1:0] = ctrl_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_STAT) begin
            rd_nxt[`ATQ_ST_ARMED] = armed_r;
            rd_nxt[`ATQ_ST_TRIG]  = trig_done_r;
            rd_nxt[`ATQ_ST_PAT]   = pat_hit;
        end else if (AVS_ADDRESS == `ATQ_OFS_DUR) begin
            rd_nxt = dur_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_PVAL) begin
            rd_nxt[`ATQ_NCH-1:0] = pval_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_PCARE) begin
            rd_nxt[`ATQ_NCH-1:0] = pcare_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_EDGE) begin
            rd_nxt = edge_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_GLEN) begin
            rd_nxt[`ATQ_NCH-1:0] = glen_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_RANGE) begin
            rd_nxt = range_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_QUAL1) begin
            rd_nxt[`ATQ_Q_W-1:0] = qual1_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_QUAL2) begin
            rd_nxt[`ATQ_Q_W-1:0] = qual2_r;
        end else if (AVS_ADDRESS == `ATQ_OFS_HITS) begin
            rd_nxt[`ATQ_NREC-1:0] = rec1;
            rd_nxt[`ATQ_NREC]     = rng1;
        end else if (AVS_ADDRESS >= `ATQ_OFS_REC &&
                     AVS_ADDRESS < `ATQ_REC_END) begin
            rd_nxt[`ATQ_NCH-1:0] = AVS_ADDRESS[2]
                ? rec_care_r[AVS_ADDRESS[5:3]]
                : rec_val_r[AVS_ADDRESS[5:3]];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            AVS_READDATA <= `ATQ_RST_Z32;
        end else if (AVS_READ && !resp_r) begin
            AVS_READDATA <= rd_nxt;
        end
    end

    // Configuration writes
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r  <= '0;
            pval_r  <= `ATQ_RST_Z16;
            pcare_r <= `ATQ_RST_Z16;
            edge_r  <= `ATQ_RST_Z32;
            glen_r  <= `ATQ_RST_Z16;
            range_r <= `ATQ_RST_Z32;
            qual1_r <= '0;
            qual2_r <= '0;
        end else if (wr_go) begin
            if (AVS_ADDRESS == `ATQ_OFS_CTRL) begin
                ctrl_r <= wdat[`ATQ_CTRL_W-1:0];
            end else if (AVS_ADDRESS == `ATQ_OFS_PVAL) begin
                pval_r <= wdat[`ATQ_NCH-1:0];
            end else if (AVS_ADDRESS == `ATQ_OFS_PCARE) begin
                pcare_r <= wdat[`ATQ_NCH-1:0];
            end else if (AVS_ADDRESS == `ATQ_OFS_EDGE) begin
                edge_r <= wdat;
            end else if (AVS_ADDRESS == `ATQ_OFS_GLEN) begin
                glen_r <= wdat[`ATQ_NCH-1:0];
            end else if (AVS_ADDRESS == `ATQ_OFS_RANGE) begin
                range_r <= wdat;
            end else if (AVS_ADDRESS == `ATQ_OFS_QUAL1) begin
                qual1_r <= wdat[`ATQ_Q_W-1:0];
            end else if (AVS_ADDRESS == `ATQ_OFS_QUAL2) begin
                qual2_r <= wdat[`ATQ_Q_W-1:0];
            end
        end
    end

    // Threshold, clamped on write and again when the sense flips
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dur_r <= `ATQ_DUR_RST;
        end else if (wr_go && AVS_ADDRESS == `ATQ_OFS_DUR) begin
            dur_r <= clamp_dur(wdat, sense_lt);               // [RL4]
        end else if (wr_go && AVS_ADDRESS == `ATQ_OFS_CTRL &&
                     AVS_BYTEENABLE[0]) begin
            dur_r <= clamp_dur(dur_r, AVS_WRITEDATA[`ATQ_CTRL_LT]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < `ATQ_NREC; i++) begin
                rec_val_r[i]  <= `ATQ_RST_Z16;
                rec_care_r[i] <= `ATQ_RST_Z16;
            end
        end else if (wr_go && AVS_ADDRESS >= `ATQ_OFS_REC &&
                     AVS_ADDRESS < `ATQ_REC_END) begin
            if (AVS_ADDRESS[2]) begin
                rec_care_r[AVS_ADDRESS[5:3]] <= wdat[`ATQ_NCH-1:0];
            end else begin
                rec_val_r[AVS_ADDRESS[5:3]] <= wdat[`ATQ_NCH-1:0];
            end
        end
    end

    // Timing pattern: each label matched, then all labels ANDed
    for (genvar l = 0; l < `ATQ_NLBL; l++) begin : g_lbl
        localparam int B = l * `ATQ_LBL_W;
        assign lbl_hit[l] = &(~pcare_r[B +: `ATQ_LBL_W] |
            ~(PROBE_DATA[B +: `ATQ_LBL_W] ^ pval_r[B +: `ATQ_LBL_W]));
    end
    assign pat_hit = &lbl_hit;                                // [RL19]

    // Per-channel edge detectors
    for (genvar c = 0; c < `ATQ_NCH; c++) begin : g_edge
        atq_edge_t m;
        logic      rise;
        logic      fall;
        assign m    = atq_edge_t'(edge_r[2*c +: 2]);          // [RL8]
        assign rise = PROBE_DATA[c] && !data_prev_r[c];
        assign fall = !PROBE_DATA[c] && data_prev_r[c];
        always_comb begin
            case (m)
                ATQ_EDGE_RISE:   edge_hit[c] = rise;
                ATQ_EDGE_FALL:   edge_hit[c] = fall;
                ATQ_EDGE_EITHER: edge_hit[c] = rise || fall;
                default:         edge_hit[c] = 1'b0;
            endcase
        end
    end

    // Front end flags only glitches of at least the minimum width
    assign edge_any   = (|edge_hit) && !sense_lt;             // [RL9] [RL6]
    assign glitch_any = (|(glen_r & PROBE_GLITCH)) &&
                        glitch_mode && !sense_lt;             // [RL12] [RL20]

    // Length of the current true interval in ns, saturating
    assign cnt_nxt = !pat_hit ? `ATQ_RST_Z32 :                // [RL21]
                     (cnt_ns_r >= MAX_NS) ? cnt_ns_r : cnt_ns_r + CLK_NS;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_ns_r    <= `ATQ_RST_Z32;
            pat_prev_r  <= 1'b0;
            data_prev_r <= `ATQ_RST_Z16;
        end else begin
            cnt_ns_r    <= cnt_nxt;
            pat_prev_r  <= pat_hit;
            data_prev_r <= PROBE_DATA;
        end
    end

    // Greater-than: arm once the interval has outlasted the threshold
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= ctrl_r[`ATQ_CTRL_RUN] && !sense_lt && pat_hit &&
                       (armed_r || cnt_nxt > dur_r);          // [RL1] [RL5]
        end
    end

    assign fire = ctrl_r[`ATQ_CTRL_RUN] && !trig_done_r && (sense_lt
        ? pat_prev_r && !pat_hit && cnt_ns_r >= OCC_MIN &&
          cnt_ns_r < dur_r                                    // [RL6] [RL7]
        : armed_r && pat_hit && (edge_any || glitch_any));    // [RL10] [RL11]

    assign rearm = wr_go && AVS_ADDRESS == `ATQ_OFS_CTRL &&
                   AVS_BYTEENABLE[0] && AVS_WRITEDATA[`ATQ_CTRL_RUN];

    // One trigger per run; a trigger in the rearm cycle is kept
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            trig_done_r <= 1'b0;
            TRIG_OUT    <= 1'b0;
        end else begin
            TRIG_OUT <= fire;
            if (fire) begin
                trig_done_r <= 1'b1;
            end else if (rearm) begin
                trig_done_r <= 1'b0;
            end
        end
    end

    // State recognizers, 0/1/don't-care per bit
    for (genvar r = 0; r < `ATQ_NREC; r++) begin : g_rec
        assign rec1[r] = &(~rec_care_r[r] |
                           ~(STATE1_DATA ^ rec_val_r[r]));    // [RL13]
        assign rec2[r] = &(~rec_care_r[r] |
                           ~(STATE2_DATA ^ rec_val_r[r]));
    end
    assign rng1 = STATE1_DATA >= range_r[15:0] &&
                  STATE1_DATA <= range_r[31:16];              // [RL16]
    assign rng2 = STATE2_DATA >= range_r[15:0] &&
                  STATE2_DATA <= range_r[31:16];

    // One group gate: OR of picks, or AND of their complements
    function automatic logic group(
        input logic [3:0] hits,
        input logic [3:0] pick,
        input logic       use_and,
        input logic       rterm,
        input logic       ron
    );
        group = use_and
            ? ((&(~hits | ~pick)) && (!ron || !rterm)) && ((|pick) || ron)
            : (|(hits & pick)) || (ron && rterm);
    endfunction

    function automatic logic qualify(
        input logic [`ATQ_Q_W-1:0]  q,
        input logic [`ATQ_NREC-1:0] rec,
        input logic                 rng,
        input logic                 rng_ok,
        input logic                 lim,
        input logic                 hi_grp
    );
        logic [2:0] idx;
        logic       rt;
        logic       ron;
        atq_rmode_t rm;
        idx = q[`ATQ_Q_IDX];
        rm  = atq_rmode_t'(q[`ATQ_Q_RMODE]);
        rt  = (rm == ATQ_R_OUT) ? !rng : rng;
        ron = (rm != ATQ_R_OFF) && rng_ok;
        if (lim) begin
            idx = {hi_grp, idx[1:0]};                         // [RL15]
        end
        case (atq_qkind_t'(q[`ATQ_Q_KIND]))
            ATQ_Q_ANY:    qualify = 1'b1;                     // [RL17]
            ATQ_Q_REC:    qualify = rec[idx];
            ATQ_Q_NREC:   qualify = !rec[idx];
            ATQ_Q_RANGE:  qualify = rng && rng_ok;
            ATQ_Q_NRANGE: qualify = !rng && rng_ok;
            ATQ_Q_COMB: begin
                if (lim && hi_grp) begin                      // [RL18]
                    qualify = |(rec[7:4] & q[`ATQ_Q_G2MASK]);
                end else if (lim) begin
                    qualify = group(rec[3:0], q[`ATQ_Q_G1MASK], 1'b0,
                                    rt, ron);
                end else begin                                // [RL14]
                    qualify = group(rec[3:0], q[`ATQ_Q_G1MASK],
                                    q[`ATQ_Q_G1AND], rt, ron) ||
                              group(rec[7:4], q[`ATQ_Q_G2MASK],
                                    q[`ATQ_Q_G2AND], 1'b0, 1'b0);
                end
            end
            default:      qualify = 1'b0;
        endcase
    endfunction

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            QUAL1_OUT <= 1'b0;
            QUAL2_OUT <= 1'b0;
        end else begin
            QUAL1_OUT <= qualify(qual1_r, rec1, rng1, 1'b1, dual, 1'b0);
            QUAL2_OUT <= dual &&
                         qualify(qual2_r, rec2, rng2, 1'b0, 1'b1, 1'b1);
        end
    end

endmodule

/* File: test_analyzer_trigger_qualifier.sv */
// Bench for the trigger qualifier: bus tasks and probe sequences.
// Assumes the probe model launches each sample one clock later.
`timescale 1ns/100ps
`include "atq_params.svh"
module test_analyzer_trigger_qualifier;
    localparam logic [31:0] full_m = 32'hFFFF_FFFF;
    logic        CORE_CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic [7:0]  AVS_ADDRESS = 8'h00;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0]  AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_READDATA, rd;
    logic        AVS_WAITREQUEST, TRIG_OUT, QUAL1_OUT, QUAL2_OUT;
    logic [15:0] PROBE_DATA, PROBE_GLITCH, STATE1_DATA, STATE2_DATA;
    logic [15:0] p_d = 16'h0, p_g = 16'h0, p_s1 = 16'h0, p_s2 = 16'h0;
    logic [15:0] sv[5] = '{16'h0012, 16'h00FF, 16'h0100, 16'h0200, 16'h0201};
    logic [31:0] hv[5] = '{32'h1, 32'h0, 32'h100, 32'h100, 32'h0};
    logic [5:0]  qv = 6'h25;
    int          n_mismatch = 0, checks = 0, trigs = 0;
    atq_trigger_qualifier #(.DUR_MAX_CYC(100)) atq_trigger_qualifier_inst (.*);
    atq_probe_model atq_probe_model_inst (
        .clk(CORE_CLK), .data_nxt(p_d), .glitch_nxt(p_g), .s1_nxt(p_s1),
        .s2_nxt(p_s2), .data_r(PROBE_DATA), .glitch_r(PROBE_GLITCH),
        .s1_r(STATE1_DATA), .s2_r(STATE2_DATA));
    initial forever #25 CORE_CLK = ~CORE_CLK;
    always @(negedge CORE_CLK) if (TRIG_OUT === 1'b1) trigs++;
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        chk(32'(n < 50), 32'h1);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic drv(input logic [15:0] d, g, input int n);
        repeat (n) begin
            p_d <= d;
            p_g <= g;
            @(posedge CORE_CLK);
        end
    endtask
    initial begin
        #500000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        @(posedge CORE_CLK);
        rdm(`ATQ_OFS_DUR, full_m, 32'h1E);
        wr(`ATQ_OFS_STAT, full_m);
        rdm(`ATQ_OFS_STAT, 32'h3, 32'h0);
        rdm(`ATQ_REC_END, full_m, 32'h0);
        wr(`ATQ_OFS_DUR, 32'h5);
        rdm(`ATQ_OFS_DUR, full_m, 32'h1E);
        wr(`ATQ_OFS_DUR, 32'h00FF_FFFF);
        rdm(`ATQ_OFS_DUR, full_m, 32'h1388);
        wr(`ATQ_OFS_CTRL, 32'h2);
        wr(`ATQ_OFS_DUR, 32'h1E);
        rdm(`ATQ_OFS_DUR, full_m, 32'h28);
        wr(`ATQ_OFS_CTRL, 32'h0);
        wr(`ATQ_OFS_PVAL, 32'h0505);
        wr(`ATQ_OFS_PCARE, 32'h0F0F);
        wr(`ATQ_OFS_DUR, 32'h78);
        for (int k = 0; k < 4; k++) begin
            wr(`ATQ_OFS_EDGE, 32'(k) << 30);
            wr(`ATQ_OFS_CTRL, 32'h1);
            trigs = 0;
            drv(16'h0505, 16'h0, 2);
            drv(16'h8505, 16'h0, 1);
            drv(16'h0505, 16'h0, 3);
            rdm(`ATQ_OFS_STAT, 32'h2, (k > 1) ? 32'h2 : 32'h0);
            drv(16'h8505, 16'h0, 1);
            drv(16'h0, 16'h0, 3);
            chk(32'(trigs), (k > 0) ? 32'h1 : 32'h0);
        end
        wr(`ATQ_OFS_EDGE, 32'h1000_0003);
        wr(`ATQ_OFS_CTRL, 32'h1);
        trigs = 0;
        drv(16'h0505, 16'h0, 3);
        drv(16'h0504, 16'h0, 2);
        drv(16'h0505, 16'h0, 3);
        rdm(`ATQ_OFS_STAT, 32'h2, 32'h0);
        drv(16'h4505, 16'h0, 1);
        drv(16'h0, 16'h0, 3);
        chk(32'(trigs), 32'h1);
        wr(`ATQ_OFS_EDGE, 32'h0);
        wr(`ATQ_OFS_GLEN, 32'h2000);
        for (int m = 0; m < 2; m++) begin
            wr(`ATQ_OFS_CTRL, 32'h1 | (32'(m) << 2));
            trigs = 0;
            drv(16'h0, 16'h2000, 1);
            drv(16'h0505, 16'h0, 3);
            drv(16'h0505, 16'h2000, 1);
            drv(16'h0, 16'h0, 3);
            chk(32'(trigs), 32'(m));
        end
        wr(`ATQ_OFS_EDGE, 32'h1000_0000);
        for (int n = 2; n < 4; n++) begin
            wr(`ATQ_OFS_CTRL, 32'h3);
            trigs = 0;
            drv(16'h0505, 16'h0, n - 1);
            drv(16'h4505, 16'h2000, 1);
            drv(16'h0, 16'h0, 3);
            chk(32'(trigs), (n == 2) ? 32'h1 : 32'h0);
        end
        wr(`ATQ_OFS_CTRL, 32'h0);
        wr(`ATQ_OFS_REC, 32'h0012);
        wr(`ATQ_OFS_REC + 8'h04, 32'hFFFF);
        wr(`ATQ_OFS_RANGE, 32'h0200_0100);
        for (int i = 0; i < 5; i++) begin
            p_s1 <= sv[i];
            repeat (3) @(posedge CORE_CLK);
            rdm(`ATQ_OFS_HITS, 32'h101, hv[i]);
        end
        p_s1 <= 16'h0012;
        for (int q = 0; q < 6; q++) begin
            wr(`ATQ_OFS_QUAL1, 32'(q));
            @(negedge CORE_CLK);
            chk(32'(QUAL1_OUT), 32'(qv[q]));
            @(posedge CORE_CLK);
        end
        wr(`ATQ_OFS_CTRL, 32'h8);
        wr(`ATQ_OFS_REC + 8'h20, 32'h0034);
        wr(`ATQ_OFS_REC + 8'h24, 32'h00FF);
        wr(`ATQ_OFS_QUAL2, 32'h2006);
        p_s2 <= 16'h5534;
        repeat (3) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        chk(32'(QUAL2_OUT), 32'h1);
        @(posedge CORE_CLK);
        p_s2 <= 16'h0150;
        wr(`ATQ_OFS_QUAL2, 32'h4);
        @(negedge CORE_CLK);
        chk(32'(QUAL2_OUT), 32'h0);
        end_sim;
    end
endmodule
bind atq_trigger_qualifier atq_checker atq_checker_inst (.*);
